//--- atc_regs.vh
/*
 * Constants for the auxiliary timer: special-function addresses, control bit
 * positions and reset values. Assumes an 8-bit special-function bus.
 */
`ifndef ATC_REGS_VH
`define ATC_REGS_VH
`define ATC_ADDR_CONTROL 8'hC8
`define ATC_ADDR_MODE 8'hC9
`define ATC_ADDR_RELOAD_LOW 8'hCA
`define ATC_ADDR_RELOAD_HIGH 8'hCB
`define ATC_ADDR_COUNT_LOW 8'hCC
`define ATC_ADDR_COUNT_HIGH 8'hCD
`define ATC_BIT_OVERFLOW_FLAG 7
`define ATC_BIT_EXTERNAL_FLAG 6
`define ATC_BIT_RECEIVE_CLOCK_SELECT 5
`define ATC_BIT_TRANSMIT_CLOCK_SELECT 4
`define ATC_BIT_EXTERNAL_ENABLE 3
`define ATC_BIT_RUN_CONTROL 2
`define ATC_BIT_COUNT_SOURCE_SELECT 1
`define ATC_BIT_CAPTURE_RELOAD_SELECT 0
`define ATC_BIT_UPDOWN_ENABLE 0
`define ATC_BIT_OUTPUT_ENABLE 1
`define ATC_RESET_CONTROL 8'h00
`define ATC_RESET_MODE 2'h0
`define ATC_RESET_WORD 16'h0000
`define ATC_COUNT_MAX 16'hFFFF
`define ATC_MACHINE_CYCLE 4'hC
`define ATC_STATE_TIME 4'h2
`endif

//--- atc_edge_detect.v
/*
 * Falling-edge detector for one pin sampled on a tick.
 * Assumes the pin is already synchronous to core_clk.
 */
`timescale 1ns/1ps
module atc_edge_detect (
    core_clk,
    rst_n,
    sample,
    pin,
    fall
);
    input wire core_clk;
    input wire rst_n;
    input wire sample;
    input wire pin;
    output reg fall;

    reg last_q;

    // A fall is a high sample followed by a low one, held for one cycle.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            last_q <= 1'b1;
            fall <= 1'b0;
        end else begin
            fall <= 1'b0;
            if (sample) begin
                last_q <= pin;
                fall <= last_q & ~pin;
            end
        end
    end
endmodule // atc_edge_detect

//--- atc_aux_timer.v
/*
 * Auxiliary 16-bit timer/counter with its control, mode, reload and count
 * registers on the special-function bus. Assumes a bus with one-cycle write
 * and read strobes and combinational-free registered read data.
 */
// Summary of operation
// RQ1: Overflow sets overflow flag; software alone clears.
// RQ2: No overflow flag while serial clock select.
// RQ3: Trigger edge capture/reload sets external flag.
// RQ4: External flag requests interrupt when enabled.
// RQ5: No external-flag interrupt in up/down mode.
// RQ6: Receive clock select routes overflows to receiver.
// RQ7: Transmit clock select routes overflows to transmitter.
// RQ8: External enable gates trigger pin edges.
// RQ9: Run control starts and stops timer.
// RQ10: Count source: machine cycles or pin falls.
// RQ11: Capture select captures on trigger edges.
// RQ12: Reload on overflow and on trigger edges.
// RQ13: Serial clocking forces auto-reload on overflow.
// RQ14: Control register at 0C8H, reset zero.
// RQ15: Reload pair is capture target, reload source.
// RQ16: Capture copies count bytes to reload bytes.
// RQ17: Overflow past 0FFFFH loads reload value.
// RQ18: Up/down enable resets to zero.
// RQ19: Writes update all bits; hardware set wins.
`timescale 1ns/1ps
`include "atc_regs.vh"
module atc_aux_timer #(
    parameter MACHINE_DIV = `ATC_MACHINE_CYCLE,
    parameter STATE_DIV = `ATC_STATE_TIME
) (
    core_clk,
    rst_n,
    sfr_addr,
    sfr_wr,
    sfr_wdata,
    sfr_rd,
    sfr_rdata,
    external_count_pin,
    trigger_pin,
    irq_enable,
    timer1_overflow,
    rx_baud_tick,
    tx_baud_tick,
    irq_request
);
    input wire core_clk;
    input wire rst_n;
    input wire [7:0] sfr_addr;
    input wire sfr_wr;
    input wire [7:0] sfr_wdata;
    input wire sfr_rd;
    output reg [7:0] sfr_rdata;
    input wire external_count_pin;
    input wire trigger_pin;
    input wire irq_enable;
    input wire timer1_overflow;
    output reg rx_baud_tick;
    output reg tx_baud_tick;
    output reg irq_request;

    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [1:0] mode_q;
    reg [15:0] reload_q;
    reg [15:0] reload_d;
    reg [15:0] count_q;
    reg [15:0] count_d;
    reg [3:0] mdiv_q;
    reg [3:0] sdiv_q;
    reg ext_fall_d;
    reg sub_tick;
    reg tick;
    reg overflow;
    reg underflow;
    reg trig_evt;
    wire machine_tick;
    wire state_tick;
    wire count_fall;
    wire trig_fall;
    wire serial_clk;
    wire run;
    wire updown;
    wire capture_mode;

    assign serial_clk = ctrl_q[`ATC_BIT_RECEIVE_CLOCK_SELECT]
                      | ctrl_q[`ATC_BIT_TRANSMIT_CLOCK_SELECT];
    assign run = ctrl_q[`ATC_BIT_RUN_CONTROL]; // RQ9
    assign updown = mode_q[`ATC_BIT_UPDOWN_ENABLE] & ~serial_clk;
    assign capture_mode = ctrl_q[`ATC_BIT_CAPTURE_RELOAD_SELECT] & ~serial_clk; // RQ13
    assign machine_tick = (mdiv_q == 4'h0);
    assign state_tick = (sdiv_q == 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Prescalers: machine cycle and state time, free running.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            mdiv_q <= 4'h0;
            sdiv_q <= 4'h0;
        end else begin
            mdiv_q <= machine_tick ? MACHINE_DIV[3:0] - 4'h1 : mdiv_q - 4'h1;
            sdiv_q <= state_tick ? STATE_DIV[3:0] - 4'h1 : sdiv_q - 4'h1;
        end
    end

    // Both pins are sampled once per machine cycle, so a level must hold a
    // full machine cycle to be seen.
    atc_edge_detect u_count_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sample(machine_tick),
        .pin(external_count_pin),
        .fall(count_fall)
    );

    atc_edge_detect u_trig_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sample(machine_tick),
        .pin(trigger_pin),
        .fall(trig_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for count, reload and control.
    always @* begin
        ext_fall_d = trig_fall & ctrl_q[`ATC_BIT_EXTERNAL_ENABLE]; // RQ8
        // Baud mode runs on state time; a timer otherwise on machine cycles.
        sub_tick = serial_clk ? state_tick : machine_tick;
        tick = run & (ctrl_q[`ATC_BIT_COUNT_SOURCE_SELECT] ? count_fall : sub_tick); // RQ9 RQ10
        overflow = 1'b0;
        underflow = 1'b0;
        // In up/down mode the trigger pin is direction, not an event.
        trig_evt = ext_fall_d & ~updown;
        count_d = count_q;
        reload_d = reload_q;
        ctrl_d = ctrl_q;
        if (tick) begin
            if (updown && !trigger_pin) begin
                if (count_q == reload_q) begin
                    underflow = 1'b1;
                    count_d = `ATC_COUNT_MAX;
                end else begin
                    count_d = count_q - 16'h0001;
                end
            end else if (count_q == `ATC_COUNT_MAX) begin
                overflow = 1'b1;
                count_d = capture_mode ? `ATC_RESET_WORD : reload_q; // RQ12 RQ13 RQ17
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
        if (trig_evt && !serial_clk) begin
            if (capture_mode) begin
                reload_d = count_q; // RQ11 RQ15 RQ16
            end else begin
                count_d = reload_q; // RQ12 RQ15
            end
        end
        // Software writes land first; hardware sets then win.
        if (sfr_wr && sfr_addr == `ATC_ADDR_CONTROL) begin
            ctrl_d = sfr_wdata; // RQ19
        end
        if (sfr_wr && sfr_addr == `ATC_ADDR_RELOAD_LOW) begin
            reload_d[7:0] = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == `ATC_ADDR_RELOAD_HIGH) begin
            reload_d[15:8] = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == `ATC_ADDR_COUNT_LOW) begin
            count_d[7:0] = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == `ATC_ADDR_COUNT_HIGH) begin
            count_d[15:8] = sfr_wdata;
        end
        if ((overflow || underflow) && !serial_clk) begin
            ctrl_d[`ATC_BIT_OVERFLOW_FLAG] = 1'b1; // RQ1 RQ2 RQ19
        end
        if (updown && (overflow || underflow)) begin
            // Toggle acts as a seventeenth count bit.
            ctrl_d[`ATC_BIT_EXTERNAL_FLAG] = ~ctrl_q[`ATC_BIT_EXTERNAL_FLAG];
        end else if (trig_evt) begin
            // In baud mode the edge still flags, acting as an extra interrupt.
            ctrl_d[`ATC_BIT_EXTERNAL_FLAG] = 1'b1; // RQ3 RQ19
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= `ATC_RESET_CONTROL; // RQ14
            mode_q <= `ATC_RESET_MODE; // RQ18
            reload_q <= `ATC_RESET_WORD;
            count_q <= `ATC_RESET_WORD;
        end else begin
            ctrl_q <= ctrl_d;
            reload_q <= reload_d;
            count_q <= count_d;
            if (sfr_wr && sfr_addr == `ATC_ADDR_MODE) begin
                mode_q <= sfr_wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: baud ticks, interrupt request and read data, all registered.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
            irq_request <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            rx_baud_tick <= ctrl_q[`ATC_BIT_RECEIVE_CLOCK_SELECT] ? overflow
                                                                   : timer1_overflow; // RQ6
            tx_baud_tick <= ctrl_q[`ATC_BIT_TRANSMIT_CLOCK_SELECT] ? overflow
                                                                    : timer1_overflow; // RQ7
            irq_request <= irq_enable & (ctrl_q[`ATC_BIT_OVERFLOW_FLAG]
                         | (ctrl_q[`ATC_BIT_EXTERNAL_FLAG]
                            & ~mode_q[`ATC_BIT_UPDOWN_ENABLE])); // RQ4 RQ5
            if (sfr_rd) begin
                case (sfr_addr)
                    `ATC_ADDR_CONTROL: sfr_rdata <= ctrl_q;
                    `ATC_ADDR_MODE: sfr_rdata <= {6'h00, mode_q};
                    `ATC_ADDR_RELOAD_LOW: sfr_rdata <= reload_q[7:0];
                    `ATC_ADDR_RELOAD_HIGH: sfr_rdata <= reload_q[15:8];
                    `ATC_ADDR_COUNT_LOW: sfr_rdata <= count_q[7:0];
                    `ATC_ADDR_COUNT_HIGH: sfr_rdata <= count_q[15:8];
                    default: sfr_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // atc_aux_timer

//--- atc_aux_timer_props.sv
/* Port checker for the auxiliary timer.
   Assumes one clock domain and a bind onto every timer instance. */
`timescale 1ns/1ps
`include "atc_regs.vh"
module atc_aux_timer_props (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire irq_enable,
    input wire timer1_overflow,
    input wire rx_baud_tick,
    input wire tx_baud_tick,
    input wire irq_request
);
    reg [5:0] ctl_q;
    wire mapped;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the software-owned control bits; hardware never touches them.
    always @(posedge core_clk) begin
        if (!rst_n) ctl_q <= 6'h00;
        else if (sfr_wr && sfr_addr == `ATC_ADDR_CONTROL) ctl_q <= sfr_wdata[5:0];
    end
    assign mapped = sfr_addr >= 8'hC8 && sfr_addr <= 8'hCD;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ctrl_read: assert property (
        sfr_rd && !sfr_wr && sfr_addr == 8'hC8 |=> sfr_rdata[5:0] == $past(ctl_q))
        else $error("control read differs from written bits");
    chk_write_back: assert property (
        sfr_wr && sfr_addr == 8'hC8 ##2 sfr_rd && sfr_addr == 8'hC8
        |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3))
        else $error("control write not seen by later read");
    chk_unmapped_zero: assert property (
        sfr_rd && !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_mode_high_zero: assert property (
        sfr_rd && sfr_addr == 8'hC9 |=> sfr_rdata[7:2] == 6'h00)
        else $error("mode upper bits not zero");
    chk_rdata_hold: assert property (
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    chk_irq_gate: assert property (
        !irq_enable |=> !irq_request)
        else $error("interrupt while disabled");
    chk_rx_timer1: assert property (
        !ctl_q[5] |-> ##1 rx_baud_tick == $past(timer1_overflow))
        else $error("receive tick not from timer 1");
    chk_tx_timer1: assert property (
        !ctl_q[4] |-> ##1 tx_baud_tick == $past(timer1_overflow))
        else $error("transmit tick not from timer 1");
    // Main scenarios reached.
    cover property (irq_request);
    cover property (rx_baud_tick && ctl_q[5]);
    cover property (sfr_rd && sfr_addr == 8'hC8);
endmodule // atc_aux_timer_props
bind atc_aux_timer atc_aux_timer_props i_atc_aux_timer_props (.core_clk, .rst_n,
    .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .irq_enable,
    .timer1_overflow, .rx_baud_tick, .tx_baud_tick, .irq_request);

//--- atc_pin_model.sv
/* Outside world of the timer: trigger pin, count pin, timer 1 pulse.
   Assumes pulled-up pins that rest high. */
`timescale 1ns/1ps
module atc_pin_model (
    input wire core_clk,
    output reg trigger_pin,
    output reg external_count_pin,
    output reg timer1_overflow
);
    // Pins rest high through their pull-ups.
    initial begin
        trigger_pin = 1'b1;
        external_count_pin = 1'b1;
        timer1_overflow = 1'b0;
    end
    // Each level must outlast one 12-clock sample period, or the fall is missed.
    task fall(input integer pin, input integer hold);
        begin
            @(posedge core_clk);
            #1;
            if (pin == 0) trigger_pin = 1'b0;
            else external_count_pin = 1'b0;
            repeat (hold) @(posedge core_clk);
            #1;
            trigger_pin = 1'b1;
            external_count_pin = 1'b1;
            repeat (hold) @(posedge core_clk);
        end
    endtask
    // One-cycle overflow pulse from timer 1.
    task t1_pulse;
        begin
            @(posedge core_clk);
            #1;
            timer1_overflow = 1'b1;
            @(posedge core_clk);
            #1;
            timer1_overflow = 1'b0;
        end
    endtask
endmodule // atc_pin_model

//--- test_atc_aux_timer.sv
/* Self-checking bench for the auxiliary timer over its special-function bus.
   Assumes the pin model drives the outside pins. */
`timescale 1ns/1ps
module test_atc_aux_timer;
    reg core_clk, rst_n, sfr_wr, sfr_rd, irq_enable;
    reg [7:0] sfr_addr, sfr_wdata, v;
    wire [7:0] sfr_rdata;
    wire external_count_pin, trigger_pin, timer1_overflow, rx_baud_tick, tx_baud_tick;
    wire irq_request;
    integer err_count, total_checks, cycles, rx_n, tx_n, i;
    atc_aux_timer #(.MACHINE_DIV(12), .STATE_DIV(2)) i_atc_aux_timer (.core_clk, .rst_n,
        .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .external_count_pin,
        .trigger_pin, .irq_enable, .timer1_overflow, .rx_baud_tick, .tx_baud_tick,
        .irq_request);
    atc_pin_model i_atc_pin_model (.core_clk, .trigger_pin, .external_count_pin,
        .timer1_overflow);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Ticks are counted on the falling edge, clear of the launching edge.
    always @(negedge core_clk) begin
        cycles = cycles + 1;
        if (rx_baud_tick === 1'b1) rx_n = rx_n + 1;
        if (tx_baud_tick === 1'b1) tx_n = tx_n + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            report_and_stop;
        end
    end
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            #1;
            sfr_addr = a;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            @(posedge core_clk);
            #1;
            sfr_wr = 1'b0;
        end
    endtask
    // Read data is registered, so it is taken one edge after the strobe.
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            @(posedge core_clk);
            #1;
            sfr_addr = a;
            sfr_rd = 1'b1;
            @(posedge core_clk);
            #1;
            sfr_rd = 1'b0;
            v = sfr_rdata;
            chk(v, exp);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, sfr_wr, sfr_rd, irq_enable, sfr_addr, sfr_wdata} = 20'h0;
        {err_count, total_checks, cycles, rx_n, tx_n} = 0;
        repeat (6) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        rdc(8'hC8, 8'h00);
        rdc(8'hC9, 8'h00);
        rdc(8'hCF, 8'h00);
        irq_enable = 1'b1;
        wr(8'hC8, 8'hC0);
        rdc(8'hC8, 8'hC0);
        chk({7'h0, irq_request}, 8'h01);
        wr(8'hC8, 8'h00);
        rdc(8'hC8, 8'h00);
        $display("register test done");
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hF0);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h04);
        repeat (260) @(posedge core_clk);
        rdc(8'hC8, 8'h84);
        chk({7'h0, irq_request}, 8'h01);
        rdc(8'hCD, 8'h12);
        // Stop the timer, then plant a known low byte so that drift is visible.
        wr(8'hC8, 8'h80);
        wr(8'hCC, 8'h5A);
        rdc(8'hCC, 8'h5A);
        repeat (40) @(posedge core_clk);
        rdc(8'hCC, 8'h5A);
        $display("overflow test done");
        wr(8'hCC, 8'hCD);
        wr(8'hCD, 8'hAB);
        wr(8'hC8, 8'h09);
        i_atc_pin_model.fall(0, 30);
        rdc(8'hCA, 8'hCD);
        rdc(8'hCB, 8'hAB);
        rdc(8'hC8, 8'h49);
        chk({7'h0, irq_request}, 8'h01);
        wr(8'hC9, 8'h01);
        rdc(8'hC9, 8'h01);
        chk({7'h0, irq_request}, 8'h00);
        wr(8'hC9, 8'h00);
        wr(8'hC8, 8'h01);
        i_atc_pin_model.fall(0, 30);
        rdc(8'hC8, 8'h01);
        wr(8'hCA, 8'h55);
        wr(8'hCB, 8'h66);
        wr(8'hC8, 8'h08);
        i_atc_pin_model.fall(0, 26);
        rdc(8'hCC, 8'h55);
        rdc(8'hCD, 8'h66);
        rdc(8'hC8, 8'h48);
        $display("trigger test done");
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h06);
        for (i = 0; i < 3; i = i + 1) i_atc_pin_model.fall(1, 30);
        wr(8'hC8, 8'h00);
        rdc(8'hCC, 8'h03);
        $display("counter test done");
        rx_n = 0;
        tx_n = 0;
        for (i = 0; i < 3; i = i + 1) i_atc_pin_model.t1_pulse;
        repeat (2) @(posedge core_clk);
        chk(rx_n[7:0], 8'h03);
        chk(tx_n[7:0], 8'h03);
        wr(8'hCA, 8'hFE);
        wr(8'hCB, 8'hFF);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h35);
        rx_n = 0;
        tx_n = 0;
        repeat (100) @(posedge core_clk);
        chk({7'h0, rx_n >= 24 && rx_n <= 26}, 8'h01);
        chk({7'h0, tx_n >= 24 && tx_n <= 26}, 8'h01);
        rdc(8'hC8, 8'h35);
        wr(8'hC8, 8'h00);
        $display("baud test done");
        report_and_stop;
    end
endmodule // test_atc_aux_timer
